// file: pkg/bsc_regs.svh
// Constants for the biphase sample correlator: widths, pattern, timing.
// Assumes a 20 MHz system clock and processor timing pulses on inputs.
`ifndef BSC_REGS_SVH
`define BSC_REGS_SVH

// Sample period in ns and system clock period in ns
`define BSC_PERIOD_NS 416000
`define BSC_CLK_NS 50
// Timing pulses (a and b together) counted per sample period
`define BSC_PULSES_PER_PERIOD 208
// Register length in samples per data bit
`define BSC_LEN 8
// Biphase zero: four lows then four highs
`define BSC_REF_PATTERN 8'h0f
// Acknowledge window in ns (two machine cycles)
`define BSC_ACK_NS 8000
`define BSC_ACK_CYC ((`BSC_ACK_NS) / (`BSC_CLK_NS))

`endif

// file: pkg/bsc_pkg.sv
// Types shared by the correlator files.
// Assumes bsc_regs.svh is included by the user files.
package bsc_pkg;

   typedef enum logic [2:0] {
      BSC_IDLE,
      BSC_CLEAR,
      BSC_SHIFT,
      BSC_LOAD,
      BSC_LATCH
   } bsc_phase_e;

   // Processor bus request group
   typedef struct packed {
      logic input_strobe;
      logic int_ack;
   } bsc_cpu_req_s;

endpackage

// file: src/bsc_sum_latch.sv
// Holding latch for the correlation sum with registered read data.
// Assumes the load pulse is one cycle wide.
`timescale 1ns/10ps
module bsc_sum_latch #(
   parameter int WIDTH = 8
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic load_i,
   input wire logic [WIDTH-1:0] sum_i,
   output logic [WIDTH-1:0] sum_o
);

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
         sum_o <= '0;
      else if (load_i)
         sum_o <= sum_i;
   end

endmodule

// file: src/bsc_correlator.sv
// Time-compressed biphase correlator with interrupt request and bus read.
// Assumes timing pulses and processor strobes are synchronous single-cycle pulses.
`timescale 1ns/10ps
`include "bsc_regs.svh"
// Operation
// - Sample period timed by counting processor timing pulses, every 416 us.
// - Each period ends with a new sum and an interrupt request.
// - Period start issues reset pulse clearing the step and correlation counters.
// - Exactly eight shift clocks step both registers.
// - Ninth clock on sample register only loads the new sample.
// - Sample register recirculates during eight comparison clocks.
// - Ninth clock inserts new bit first, shifts older, drops oldest.
// - Both registers are eight bits long.
// - Reference pattern loaded in parallel at start of each cycle.
// - Mismatch of register outputs increments correlation counter.
// - Counter copied to holding latch by dedicated latch pulse.
// - Input is one clipped bit, sampled once per period.
// - Only the biphase zero pattern is held.
// - Request set each period, cleared on processor acknowledge.
// - Sum driven on data bus only during input instruction.
module bsc_correlator #(
   parameter int LEN = `BSC_LEN,
   parameter int PERIOD_PULSES = `BSC_PULSES_PER_PERIOD,
   parameter logic [`BSC_LEN-1:0] REF_PATTERN = `BSC_REF_PATTERN
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic timing_pulse_a_i,
   input wire logic timing_pulse_b_i,
   input wire logic clipped_data_i,
   input wire bsc_pkg::bsc_cpu_req_s cpu_req_i,
   output logic int_req_o,
   output logic [7:0] data_o,
   output logic [7:0] data_oe_o,
   output logic [7:0] sum_o,
   output logic period_reset_o
);

   localparam int CW = $clog2(LEN + 1);
   localparam int PW = $clog2(PERIOD_PULSES + 1);
   localparam int SW = $clog2(LEN + 2);

   bsc_pkg::bsc_phase_e phase_q, phase_d;
   logic [PW-1:0] pulse_cnt_q;
   logic [SW-1:0] step_q;
   logic [LEN-1:0] moving_sample_register_q;
   logic [LEN-1:0] reference_pattern_register_q;
   logic [CW-1:0] corr_cnt_q;
   logic sample_q;
   logic int_req_q;
   logic [7:0] latched_sum;

   wire any_pulse = timing_pulse_a_i | timing_pulse_b_i;
   wire period_end = any_pulse && (pulse_cnt_q == PW'(PERIOD_PULSES - 1));
   wire shifting = (phase_q == bsc_pkg::BSC_SHIFT);
   wire mismatch = moving_sample_register_q[LEN-1] ^ reference_pattern_register_q[LEN-1];
   wire last_shift = shifting && (step_q == SW'(LEN - 1));
   wire latch_pulse = (phase_q == bsc_pkg::BSC_LATCH);

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
         pulse_cnt_q <= '0;
      else if (period_end)
         pulse_cnt_q <= '0;
      else if (any_pulse)
         pulse_cnt_q <= pulse_cnt_q + PW'(1);
   end

   always_comb
   begin
      phase_d = phase_q;
      unique case (phase_q)
         bsc_pkg::BSC_IDLE:
            if (period_end)
               phase_d = bsc_pkg::BSC_CLEAR;
         bsc_pkg::BSC_CLEAR:
            phase_d = bsc_pkg::BSC_SHIFT;
         bsc_pkg::BSC_SHIFT:
            if (last_shift)
               phase_d = bsc_pkg::BSC_LOAD;
         bsc_pkg::BSC_LOAD:
            phase_d = bsc_pkg::BSC_LATCH;
         bsc_pkg::BSC_LATCH:
            phase_d = bsc_pkg::BSC_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
         phase_q <= bsc_pkg::BSC_IDLE;
      else
         phase_q <= phase_d;
   end

   assign period_reset_o = (phase_q == bsc_pkg::BSC_CLEAR);

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
         sample_q <= 1'b0;
      else if (period_end)
         sample_q <= clipped_data_i;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i || period_reset_o)
         step_q <= '0;
      else if (shifting)
         step_q <= step_q + SW'(1);
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
         moving_sample_register_q <= '0;
      else if (shifting)
         moving_sample_register_q <= {moving_sample_register_q[LEN-2:0], moving_sample_register_q[LEN-1]};
      else if (phase_q == bsc_pkg::BSC_LOAD)
         moving_sample_register_q <= {moving_sample_register_q[LEN-2:0], sample_q};
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i || period_reset_o)
         reference_pattern_register_q <= REF_PATTERN;
      else if (shifting)
         reference_pattern_register_q <= {reference_pattern_register_q[LEN-2:0],
                                           reference_pattern_register_q[LEN-1]};
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i || period_reset_o)
         corr_cnt_q <= '0;
      else if (shifting && mismatch)
         corr_cnt_q <= corr_cnt_q + CW'(1);
   end

   bsc_sum_latch #(
      .WIDTH(8)
   ) u_latch (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .load_i(latch_pulse),
      .sum_i(8'(corr_cnt_q)),
      .sum_o(latched_sum)
   );

   assign sum_o = latched_sum;

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
         int_req_q <= 1'b0;
      else if (latch_pulse)
         int_req_q <= 1'b1;
      else if (cpu_req_i.int_ack)
         int_req_q <= 1'b0;
   end

   assign int_req_o = int_req_q;

   assign data_o = latched_sum;
   assign data_oe_o = {8{cpu_req_i.input_strobe}};

   // Assertions
   sequence s_clear;
      period_reset_o;
   endsequence

   sequence s_shift8;
      shifting [*8];
   endsequence

   sequence s_load;
      (phase_q == bsc_pkg::BSC_LOAD);
   endsequence

   sequence s_latch;
      latch_pulse;
   endsequence

   AST_SHIFT_EIGHT: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      period_reset_o |=> s_shift8 ##1 (phase_q == bsc_pkg::BSC_LOAD))
      else $error("shift count not eight");

   AST_RESET_CLEARS: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      period_reset_o |=> (corr_cnt_q == '0) && (step_q == '0))
      else $error("period reset did not clear counters");

   AST_RECIRC: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      period_reset_o |=> ##8 (moving_sample_register_q == $past(moving_sample_register_q, 8)))
      else $error("moving register not restored");

   AST_INSERT: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (phase_q == bsc_pkg::BSC_LOAD) |=>
      (moving_sample_register_q == {$past(moving_sample_register_q[LEN-2:0]), $past(sample_q)}))
      else $error("new sample not inserted");

   AST_REF_LOAD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      period_reset_o |=> (reference_pattern_register_q == REF_PATTERN))
      else $error("reference not loaded");

   AST_COUNT: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (shifting && mismatch) |=> (corr_cnt_q == $past(corr_cnt_q) + CW'(1)))
      else $error("mismatch not counted");

   AST_LATCH: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      latch_pulse |=> (sum_o == 8'($past(corr_cnt_q))) && int_req_o)
      else $error("sum not latched or request not set");

   AST_PERIOD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      period_end |-> ##[11:11] latch_pulse)
      else $error("sum not produced after period end");

   AST_ACK: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (cpu_req_i.int_ack && !latch_pulse) |=> !int_req_o)
      else $error("request not cleared on acknowledge");

   AST_BUS: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (data_oe_o != 8'h00) |-> cpu_req_i.input_strobe && (data_o == sum_o))
      else $error("bus driven outside input");

   // Whole sample cycle, step by step
   AST_CYCLE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (period_end && (phase_q == bsc_pkg::BSC_IDLE)) |=>
      s_clear ##1 s_shift8 ##1 s_load ##1 s_latch)
      else $error("sample cycle out of order");

   AST_RESET_ONE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      period_reset_o |=> !period_reset_o)
      else $error("period reset wider than one cycle");

   AST_STEP_MAX: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      step_q <= SW'(LEN))
      else $error("step counter beyond eight");

   AST_REF_STILL: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (phase_q == bsc_pkg::BSC_LOAD) |=> $stable(reference_pattern_register_q))
      else $error("reference shifted on ninth clock");

   AST_LOAD_ONE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (phase_q == bsc_pkg::BSC_LOAD) |=> latch_pulse && !shifting)
      else $error("ninth clock not followed by latch");

   AST_REF_HOLD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      !shifting |-> (reference_pattern_register_q == REF_PATTERN))
      else $error("reference pattern not restored");

   AST_MREG_IDLE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (!shifting && (phase_q != bsc_pkg::BSC_LOAD)) |=> $stable(moving_sample_register_q))
      else $error("moving register changed outside cycle");

   AST_CNT_IDLE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (!shifting && !period_reset_o) |=> $stable(corr_cnt_q))
      else $error("counter changed outside comparison");

   AST_CNT_MATCH: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (shifting && !mismatch) |=> $stable(corr_cnt_q))
      else $error("counter changed on match");

   AST_CNT_MAX: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      corr_cnt_q <= CW'(LEN))
      else $error("counter beyond register length");

   AST_SUM_HOLD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      !latch_pulse |=> $stable(sum_o))
      else $error("sum changed without latch pulse");

   AST_SUM_MAX: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      sum_o <= 8'(LEN))
      else $error("sum beyond register length");

   AST_REQ_HOLD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (int_req_o && !cpu_req_i.int_ack) |=> int_req_o)
      else $error("request dropped without acknowledge");

   AST_REQ_ORIGIN: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      $rose(int_req_o) |-> $past(latch_pulse))
      else $error("request raised without new sum");

   AST_SAMPLE_HOLD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      !period_end |=> $stable(sample_q))
      else $error("input sampled outside period end");

   AST_BUS_OFF: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      !cpu_req_i.input_strobe |-> (data_oe_o == 8'h00))
      else $error("bus enabled without input");

   AST_PULSE_COUNT: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      pulse_cnt_q < PW'(PERIOD_PULSES))
      else $error("period counter beyond terminal count");

endmodule

// file: test/bsc_cpu_model.sv
// Processor model: timing pulses, interrupt service with bus read and acknowledge.
// Assumes the correlator raises a level request and drives the bus on strobe.
`timescale 1ns/10ps
module bsc_cpu_model (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic int_req_i,
   input wire logic [7:0] data_i,
   input wire logic [7:0] data_oe_i,
   input wire logic [3:0] ack_dly_i,
   output logic timing_pulse_a_o,
   output logic timing_pulse_b_o,
   output bsc_pkg::bsc_cpu_req_s cpu_req_o,
   output logic [7:0] read_sum_o
);
   logic [1:0] ph_q;
   logic [1:0] st_q;
   logic [3:0] wait_q;
   // Pulse a then b, one pulse every second cycle
   always @(negedge clk_sys_i)
   begin
      ph_q <= rst_i ? 2'h0 : ph_q + 2'h1;
      timing_pulse_a_o <= !rst_i && ph_q == 2'h0;
      timing_pulse_b_o <= !rst_i && ph_q == 2'h2;
   end
   always @(negedge clk_sys_i)
   begin
      // Strobe at end of wait, acknowledge after read
      cpu_req_o <= {(st_q == 2'h1) && (wait_q == 4'h0), st_q == 2'h2};
      case (st_q)
         2'h0: if (!rst_i && int_req_i)
         begin
            st_q <= 2'h1;
            wait_q <= ack_dly_i;
         end
         2'h1: if (wait_q == 4'h0)
         begin
            st_q <= 2'h2;
         end
         else wait_q <= wait_q - 4'h1;
         2'h2:
         begin
            // Undriven bus shows the inverse of the last value
            read_sum_o <= (data_oe_i === 8'hff) ? data_i : ~read_sum_o;
            st_q <= 2'h3;
         end
         default: st_q <= 2'h0;
      endcase
   end
endmodule

// file: test/tb.sv
// Testbench for the correlator: random and hand-picked sample streams.
// Assumes the processor model services every request well inside a period.
`timescale 1ns/10ps
`include "bsc_regs.svh"
module tb;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic clipped_data = 1'b0;
   logic [3:0] ack_dly = 4'h0;
   logic timing_pulse_a, timing_pulse_b, int_req_o, period_reset_o;
   logic [7:0] data_o, data_oe_o, sum_o, read_sum, mreg, exp_sum;
   bsc_pkg::bsc_cpu_req_s cpu_req;
   int num_errors = 0;
   int check_count = 0;
   int seed = 22737;
   int cyc = 0;
   int t0, tp;
   logic [15:0] pat = 16'h0ff0;
   always #25 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) cyc <= cyc + 1;
   bsc_correlator #(.PERIOD_PULSES(20)) bsc_correlator_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .timing_pulse_a_i(timing_pulse_a), .timing_pulse_b_i(timing_pulse_b), .clipped_data_i(clipped_data), .cpu_req_i(cpu_req),
      .int_req_o(int_req_o), .data_o(data_o), .data_oe_o(data_oe_o), .sum_o(sum_o),
      .period_reset_o(period_reset_o));
   bsc_cpu_model bsc_cpu_model_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .int_req_i(int_req_o),
      .data_i(data_o), .data_oe_i(data_oe_o), .ack_dly_i(ack_dly), .timing_pulse_a_o(timing_pulse_a),
      .timing_pulse_b_o(timing_pulse_b), .cpu_req_o(cpu_req), .read_sum_o(read_sum));
   task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask
   function logic [7:0] mismatches(input logic [7:0] v);
      mismatches = 8'h00;
      for (int i = 0; i < 8; i++) mismatches += {7'h00, v[i]};
   endfunction
   task wait_sig(input int sel);
      int n;
      n = 0;
      while (n < 200 && !(sel == 0 ? period_reset_o === 1'b1 : sel == 1 ? int_req_o === 1'b1 :
             cpu_req.int_ack === 1'b1))
      begin
         @(negedge clk_sys_i);
         n++;
      end
      if (n == 200) chk("wait", 8'h00, 8'h01);
   endtask
   task wrap_up;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(negedge clk_sys_i)
   begin
      if (!rst_i)
      begin
         chk("data_oe", {8{cpu_req.input_strobe}}, data_oe_o);
         if (cpu_req.int_ack === 1'b1) chk("int_req_ack", 8'h00, {7'h00, int_req_o});
      end
   end
   initial
   begin
      #200000;
      num_errors++;
      wrap_up();
   end
   initial
   begin
      mreg = 8'h00;
      tp = 0;
      repeat (6) @(negedge clk_sys_i);
      rst_i <= 1'b0;
      for (int k = 0; k < 40; k++)
      begin
         wait_sig(0);
         t0 = cyc;
         if (tp > 0) chk("period", 8'd40, 8'(t0 - tp));
         tp = t0;
         wait_sig(1);
         chk("latency", 8'd11, 8'(cyc - t0));
         exp_sum = mismatches(mreg ^ `BSC_REF_PATTERN);
         mreg = {mreg[6:0], clipped_data};
         chk("sum", exp_sum, sum_o);
         wait_sig(2);
         chk("read", exp_sum, read_sum);
         clipped_data = (k < 16) ? pat[15 - k] : 1'($random(seed));
         ack_dly = (k < 2) ? {4{k[0]}} : 4'($random(seed));
         if (k == 19)
         begin
            // Mid-run reset: state and history start over
            rst_i <= 1'b1;
            repeat (3) @(negedge clk_sys_i);
            chk("rst_sum", 8'h00, sum_o);
            chk("rst_req", 8'h00, {7'h00, int_req_o});
            rst_i <= 1'b0;
            mreg = 8'h00;
            tp = 0;
         end
      end
      wrap_up();
   end
endmodule
